/* pkg/pwm8_pkg.sv */
// Purpose: Types shared by the 8-bit PWM timer
// Assumes: Constants live in pwm8_regs.svh
// Notes:   Whole block state is one packed struct
package pwm8_pkg;

  // Waveform select encodings
  typedef enum logic [1:0] {
    WS_NORMAL = 2'b00,
    WS_PHASE  = 2'b01,
    WS_CTC    = 2'b10,
    WS_FAST   = 2'b11
  } wave_e;

  // Output action select encodings
  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } act_e;

  // Complete block state
  typedef struct packed {
    wave_e       ws;
    act_e        com;
    logic [2:0]  cs;
    logic [9:0]  pre;
    logic [7:0]  cnt;
    logic        up;
    logic        blk;
    logic [7:0]  ocr_buf;
    logic [7:0]  ocr_act;
    logic        oc;
    logic        ovf;
    logic        cmf;
    logic        dir;
    logic        pval;
    logic        pin_o;
    logic        pin_oe;
    logic [7:0]  rdata;
  } state_s;

endpackage : pwm8_pkg

/* pkg/pwm8_regs.svh */
// Purpose: Register offsets, field positions, reset values and counter limits
// Assumes: Byte addresses on a 5-bit plain register port, 8-bit data
// Notes:   Definitions only
`ifndef PWM8_REGS_SVH
`define PWM8_REGS_SVH

// Register byte addresses
`define ADDR_CTRL      5'h00
`define ADDR_COUNT     5'h04
`define ADDR_COMPARE   5'h08
`define ADDR_PORT      5'h0C
`define ADDR_STATUS    5'h10

// Control field positions
`define CTRL_WS_LSB    0
`define CTRL_COM_LSB   2
`define CTRL_CS_LSB    4

// Port and status bit positions
`define PORT_DIR_BIT   0
`define PORT_VAL_BIT   1
`define STAT_OVF_BIT   0
`define STAT_CMF_BIT   1

// Reset values
`define CTRL_RST       8'h00
`define COMPARE_RST    8'h00

// Counter limits
`define CNT_MAX        8'hFF
`define CNT_BOTTOM     8'h00

`endif

/* src/pwm8_timer.sv */
// Purpose: 8-bit timer with fast and phase-correct PWM on one compare pin
// Assumes: Single 40 MHz clock, plain register port, read data one cycle later
// Notes:   Timer advances on a prescaled one-cycle tick enable
//
// Function
// - Select 3 runs single-slope fast PWM
// - Fast action 2: clear on match, set BOTTOM
// - Fast action 3: set on match, clear BOTTOM
// - Fast: MAX clears to BOTTOM next tick
// - Fast: overflow flag set at MAX
// - Pin driven only when direction is output
// - Fast extremes: BOTTOM spike, MAX constant level
// - Fast action 1 toggles output on match
// - Fast: compare writes go to buffer
// - Select 1 runs dual-slope phase-correct PWM
// - Phase action 2: clear up, set down
// - Phase action 3: set up, clear down
// - Phase: eight bits, MAX held one tick
// - Phase: overflow flag set at BOTTOM
// - Phase extremes with action 2: BOTTOM low, MAX high
// - Phase: at MAX force up-match level, down-match level if compare buffer is MAX
// - Phase: missed up-match still gives transition
// - Fast period 256 prescaled ticks
// - Phase period 510 prescaled ticks
// - Counter advances on single-cycle tick enable
// - Action 0 leaves pin to port
// - Nonzero action overrides port in any mode
// - MAX is 0xFF, BOTTOM is 0x00
`include "pwm8_regs.svh"

module pwm8_timer
  import pwm8_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // Register port
  input  wire logic [4:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Compare pin
  output logic             PIN_O,
  output logic             PIN_OE,
  // Flags
  output logic             OVERFLOW_FLAG,
  output logic             COMPARE_MATCH_FLAG
);

  state_s q;
  state_s d;
  logic   tick;
  logic   hit;
  logic   at_top;
  logic   pwm;

  // Prescaled tick from the free-running divider
  function automatic logic tick_of(input logic [2:0] cs,
                                   input logic [9:0] pre);
    logic t;
    t = 1'b0;
    unique case (cs)
      3'h0: t = 1'b0;
      3'h1: t = 1'b1;
      3'h2: t = &pre[2:0];
      3'h3: t = &pre[4:0];
      3'h4: t = &pre[5:0];
      3'h5: t = &pre[6:0];
      3'h6: t = &pre[7:0];
      3'h7: t = &pre[9:0];
    endcase
    return t;
  endfunction : tick_of

  // Shared match and boundary terms
  assign tick   = tick_of(q.cs, q.pre);
  assign hit    = tick && (q.cnt == q.ocr_act) && !q.blk;
  assign at_top = tick && (q.cnt == `CNT_MAX);
  assign pwm    = (q.ws == WS_FAST) || (q.ws == WS_PHASE);

  // Next-state logic
  always_comb begin
    d       = q;
    d.pre   = q.pre + 10'h001;
    d.rdata = 8'h00;

    // Flag clears first so that a hardware set wins
    if (WR && ADDR == `ADDR_STATUS) begin
      if (WDATA[`STAT_OVF_BIT]) d.ovf = 1'b0;
      if (WDATA[`STAT_CMF_BIT]) d.cmf = 1'b0;
    end

    if (tick) d.blk = 1'b0;
    if (hit) d.cmf = 1'b1;

    unique case (q.ws)
      WS_FAST: begin
        if (tick) begin
          d.cnt = at_top ? `CNT_BOTTOM : q.cnt + 8'h01;
        end
        if (hit) begin
          unique case (q.com)
            ACT_NONE:   d.oc = q.oc;
            ACT_TOGGLE: d.oc = ~q.oc;
            ACT_CLEAR:  d.oc = 1'b0;
            ACT_SET:    d.oc = 1'b1;
          endcase
        end
        // BOTTOM action wins over a match at MAX
        if (at_top) begin
          d.ovf     = 1'b1;
          d.ocr_act = q.ocr_buf;
          if (q.com == ACT_CLEAR) d.oc = 1'b1;
          if (q.com == ACT_SET) d.oc = 1'b0;
        end
      end
      WS_PHASE: begin
        // Up to MAX, one tick at MAX, down to BOTTOM
        if (tick) begin
          if (q.up) begin
            if (q.cnt == `CNT_MAX) begin
              d.cnt = `CNT_MAX - 8'h01;
              d.up  = 1'b0;
            end else begin
              d.cnt = q.cnt + 8'h01;
            end
          end else if (q.cnt == `CNT_BOTTOM + 8'h01) begin
            d.cnt = `CNT_BOTTOM;
            d.up  = 1'b1;
            d.ovf = 1'b1;
          end else if (q.cnt == `CNT_BOTTOM) begin
            d.cnt = q.cnt + 8'h01;
            d.up  = 1'b1;
          end else begin
            d.cnt = q.cnt - 8'h01;
          end
        end
        // A match at BOTTOM counts as up-counting
        if (hit) begin
          if (q.up || q.cnt == `CNT_BOTTOM) begin
            if (q.com == ACT_CLEAR) d.oc = 1'b0;
            if (q.com == ACT_SET) d.oc = 1'b1;
          end else begin
            if (q.com == ACT_CLEAR) d.oc = 1'b1;
            if (q.com == ACT_SET) d.oc = 1'b0;
          end
        end
        // At MAX take new value and restore symmetry
        if (at_top) begin
          d.ocr_act = q.ocr_buf;
          if (q.ocr_buf == `CNT_MAX) begin
            if (q.com == ACT_CLEAR) d.oc = 1'b1;
            if (q.com == ACT_SET) d.oc = 1'b0;
          end else begin
            if (q.com == ACT_CLEAR) d.oc = 1'b0;
            if (q.com == ACT_SET) d.oc = 1'b1;
          end
        end
      end
      WS_NORMAL, WS_CTC: begin
        // Up-count, CTC clears to BOTTOM on match, compare value unbuffered
        d.ocr_act = q.ocr_buf;
        d.up      = 1'b1;
        if (tick) begin
          if (q.ws == WS_CTC && hit) d.cnt = `CNT_BOTTOM;
          else d.cnt = q.cnt + 8'h01;
          if (at_top) d.ovf = 1'b1;
        end
        if (hit) begin
          unique case (q.com)
            ACT_NONE:   d.oc = q.oc;
            ACT_TOGGLE: d.oc = ~q.oc;
            ACT_CLEAR:  d.oc = 1'b0;
            ACT_SET:    d.oc = 1'b1;
          endcase
        end
      end
    endcase

    // Register writes
    if (WR) begin
      unique case (ADDR)
        `ADDR_CTRL: begin
          d.ws  = wave_e'(WDATA[`CTRL_WS_LSB +: 2]);
          d.com = act_e'(WDATA[`CTRL_COM_LSB +: 2]);
          d.cs  = WDATA[`CTRL_CS_LSB +: 3];
        end
        `ADDR_COUNT: begin
          d.cnt = WDATA;
          d.blk = 1'b1;                                  // Blocks next match
        end
        `ADDR_COMPARE: begin
          d.ocr_buf = WDATA;
          if (!pwm) d.ocr_act = WDATA;
        end
        `ADDR_PORT: begin
          d.dir  = WDATA[`PORT_DIR_BIT];
          d.pval = WDATA[`PORT_VAL_BIT];
        end
        default: d.pre = d.pre;
      endcase
    end

    // Register reads, valid the following cycle only
    if (RD) begin
      unique case (ADDR)
        `ADDR_CTRL:    d.rdata = {1'b0, q.cs, q.com, q.ws};
        `ADDR_COUNT:   d.rdata = q.cnt;
        `ADDR_COMPARE: d.rdata = q.ocr_buf;
        `ADDR_PORT:    d.rdata = {6'h00, q.pval, q.dir};
        `ADDR_STATUS:  d.rdata = {5'h00, q.oc, q.cmf, q.ovf};
        default:       d.rdata = 8'h00;
      endcase
    end

    // Pin mux and direction
    d.pin_oe = q.dir;
    d.pin_o  = (q.com != ACT_NONE) ? q.oc : q.pval;
  end

  // State register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= '0;                                           // All-zero reset image
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign RDATA              = q.rdata;
  assign PIN_O              = q.pin_o;
  assign PIN_OE             = q.pin_oe;
  assign OVERFLOW_FLAG      = q.ovf;
  assign COMPARE_MATCH_FLAG = q.cmf;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_fast_top;
    tick && q.ws == WS_FAST && q.cnt == `CNT_MAX && !WR;
  endsequence

  sequence s_pc_near_top;
    tick && q.ws == WS_PHASE && q.up && q.cnt == 8'hFE && !WR;
  endsequence

  sequence s_pc_top;
    tick && q.ws == WS_PHASE && q.up && q.cnt == `CNT_MAX && !WR;
  endsequence

  // Match on the rising slope, BOTTOM included
  sequence s_pc_hit_up;
    hit && q.ws == WS_PHASE && (q.up || q.cnt == `CNT_BOTTOM) && !at_top && !WR;
  endsequence

  // Match on the falling slope
  sequence s_pc_hit_down;
    hit && q.ws == WS_PHASE && !q.up && q.cnt != `CNT_BOTTOM && !at_top && !WR;
  endsequence

  property p_fast_wrap;
    s_fast_top |=> q.cnt == `CNT_BOTTOM && q.ovf;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap)
    else $error("fast mode did not wrap with overflow");

  property p_fast_bottom_set;
    s_fast_top ##0 (q.com == ACT_CLEAR) |=> q.oc;
  endproperty
  a_fast_bottom_set: assert property (p_fast_bottom_set)
    else $error("non-inverted output not set at bottom");

  property p_fast_bottom_clr;
    s_fast_top ##0 (q.com == ACT_SET) |=> !q.oc;
  endproperty
  a_fast_bottom_clr: assert property (p_fast_bottom_clr)
    else $error("inverted output not cleared at bottom");

  property p_fast_toggle;
    hit && q.ws == WS_FAST && q.com == ACT_TOGGLE && !WR
      |=> q.oc != $past(q.oc);
  endproperty
  a_fast_toggle: assert property (p_fast_toggle)
    else $error("toggle action missing");

  property p_buffer_hold;
    pwm && !at_top && !WR |=> q.ocr_act == $past(q.ocr_act);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold)
    else $error("active compare changed off boundary");

  property p_buffer_load;
    at_top && pwm && !WR |=> q.ocr_act == $past(q.ocr_buf);
  endproperty
  a_buffer_load: assert property (p_buffer_load)
    else $error("buffer not loaded at top");

  property p_pc_hold_top;
    s_pc_near_top |=> q.cnt == `CNT_MAX && q.up;
  endproperty
  a_pc_hold_top: assert property (p_pc_hold_top)
    else $error("phase mode did not reach top");

  property p_pc_turn;
    s_pc_top |=> q.cnt == `CNT_MAX - 8'h01 && !q.up;
  endproperty
  a_pc_turn: assert property (p_pc_turn)
    else $error("phase mode held top longer than one tick");

  property p_pc_ovf;
    tick && q.ws == WS_PHASE && !q.up && q.cnt == 8'h01 && !WR
      |=> q.cnt == `CNT_BOTTOM && q.ovf && q.up;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf)
    else $error("phase mode overflow at bottom missing");

  property p_pc_force;
    at_top && q.ws == WS_PHASE && q.com == ACT_CLEAR
      && q.ocr_buf != `CNT_MAX && !WR |=> !q.oc;
  endproperty
  a_pc_force: assert property (p_pc_force)
    else $error("up-match level not forced at top");

  property p_pin_override;
    q.com != ACT_NONE |=> PIN_O == $past(q.oc) && PIN_OE == $past(q.dir);
  endproperty
  a_pin_override: assert property (p_pin_override)
    else $error("pin not driven from compare output");

  property p_flag_set_wins;
    hit && WR && ADDR == `ADDR_STATUS |=> q.cmf;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("match flag lost to a clear");

  property p_fast_match_clr;
    hit && q.ws == WS_FAST && q.com == ACT_CLEAR && !at_top && !WR |=> !q.oc;
  endproperty
  a_fast_match_clr: assert property (p_fast_match_clr)
    else $error("non-inverted output not cleared on match");

  property p_fast_match_set;
    hit && q.ws == WS_FAST && q.com == ACT_SET && !at_top && !WR |=> q.oc;
  endproperty
  a_fast_match_set: assert property (p_fast_match_set)
    else $error("inverted output not set on match");

  property p_pc_up_clr;
    s_pc_hit_up ##0 (q.com == ACT_CLEAR) |=> !q.oc;
  endproperty
  a_pc_up_clr: assert property (p_pc_up_clr)
    else $error("non-inverted output not cleared on rising match");

  property p_pc_down_set;
    s_pc_hit_down ##0 (q.com == ACT_CLEAR) |=> q.oc;
  endproperty
  a_pc_down_set: assert property (p_pc_down_set)
    else $error("non-inverted output not set on falling match");

  property p_pc_up_set;
    s_pc_hit_up ##0 (q.com == ACT_SET) |=> q.oc;
  endproperty
  a_pc_up_set: assert property (p_pc_up_set)
    else $error("inverted output not set on rising match");

  property p_pc_down_clr;
    s_pc_hit_down ##0 (q.com == ACT_SET) |=> !q.oc;
  endproperty
  a_pc_down_clr: assert property (p_pc_down_clr)
    else $error("inverted output not cleared on falling match");

  property p_port_mode;
    q.com == ACT_NONE |=> PIN_O == $past(q.pval);
  endproperty
  a_port_mode: assert property (p_port_mode)
    else $error("pin not under port control with action zero");

  property p_count_hold;
    !tick && !WR |=> q.cnt == $past(q.cnt);
  endproperty
  a_count_hold: assert property (p_count_hold)
    else $error("counter moved without a tick");

endmodule : pwm8_timer

/* testbench/pwm8_pin_load.sv */
// Purpose: Load model of the compare pin, standing outside the timer
// Assumes: Pin has no pull resistor; one clock domain
// Notes:   Wire wanders every cycle while nothing drives it
module pwm8_pin_load (
  // Clock
  input  wire logic clk,
  // Drive from the timer
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Level seen on the wire
  output logic      pin_lvl
);
  timeunit 1ns;
  timeprecision 100ps;

  logic float_q = 1'b0;

  // Floating wire pattern, so a stale level never passes for a drive
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Wire shows the drive only while enabled
  assign pin_lvl = pin_oe ? pin_o : float_q;

endmodule : pwm8_pin_load

/* testbench/timer8_pwm_waveform_modes_bench.sv */
// Purpose: Self-checking bench for the 8-bit PWM timer
// Assumes: 40 MHz clock, pin enabled as output for waveform checks
// Notes:   Duty is counted over one full period after the mode settles
`include "pwm8_regs.svh"

module timer8_pwm_waveform_modes_bench import pwm8_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       rstn;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       pin_o;
  logic       pin_oe;
  logic       pin_lvl;
  logic       ovf;
  logic       cmf;
  int         errors;
  int         cmp_count;

  // Device and pin load
  pwm8_timer uut (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PIN_O(pin_o), .PIN_OE(pin_oe), .OVERFLOW_FLAG(ovf), .COMPARE_MATCH_FLAG(cmf)
  );
  pwm8_pin_load pin_model (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t %s: seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic t_reset();
    logic [7:0] v;
    check(pin_oe, 1'b0, "oe after reset");
    reg_rd(`ADDR_CTRL, v);
    check(v, `CTRL_RST, "ctrl reset");
    reg_rd(`ADDR_COMPARE, v);
    check(v, `COMPARE_RST, "compare reset");
    reg_rd(5'h1C, v);
    check(v, 8'h00, "unmapped read");
  endtask : t_reset

  task automatic t_dir();
    reg_wr(`ADDR_PORT, 8'h02);
    repeat (2) @(posedge clk);
    #1 check(pin_oe, 1'b0, "oe input");
    reg_wr(`ADDR_PORT, 8'h03);
    repeat (2) @(posedge clk);
    #1 check(pin_oe, 1'b1, "oe output");
    check(pin_lvl, 1'b1, "port level");
  endtask : t_dir

  // Back-to-back count reads; each value must follow from the last two
  task automatic t_seq(input logic [7:0] ctrl, input bit phase, input int n);
    logic [7:0] prev;
    logic [7:0] cur;
    logic [7:0] exp;
    reg_wr(`ADDR_CTRL, ctrl);
    @(posedge clk);
    addr <= `ADDR_COUNT;
    rd   <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1 cur = rdata;
      if (i > 1)
        check(cur, exp, "count step");
      exp  = (!phase || (cur > prev && cur != `CNT_MAX) || cur == `CNT_BOTTOM) ? cur + 8'h01 : cur - 8'h01;
      prev = cur;
    end
    @(posedge clk);
    rd <= 1'b0;
  endtask : t_seq

  // Spacing of two overflow flag sets, in clock cycles
  task automatic t_period(input logic [7:0] ctrl, input int exp);
    time t0;
    int  n;
    reg_wr(`ADDR_CTRL, ctrl);
    for (int k = 0; k < 2; k++) begin
      reg_wr(`ADDR_STATUS, 8'h01);
      #1 n = 0;
      while (ovf !== 1'b1 && n < 5000) begin
        @(posedge clk);
        #1 n++;
      end
      if (k == 0)
        t0 = $time;
    end
    check(16'(($time - t0) / 25), 16'(exp), "period");
  endtask : t_period

  // High cycles on the wire over one window after settling
  task automatic t_duty(input logic [7:0] ctrl, input logic [7:0] cmp, input int win, input int exp);
    logic [7:0] v;
    int         hi;
    reg_wr(`ADDR_COMPARE, cmp);
    reg_rd(`ADDR_COMPARE, v);
    check(v, cmp, "compare buffer");
    reg_wr(`ADDR_CTRL, ctrl);
    repeat (1100) @(posedge clk);
    hi = 0;
    for (int i = 0; i < win; i++) begin
      @(posedge clk);
      #1 hi += (pin_lvl === 1'b1);
    end
    check(16'(hi), 16'(exp), "high cycles");
  endtask : t_duty

  // Match flag set in the cycle of its clear, then a plain clear; runs after the normal-mode duty case
  task automatic t_flag();
    logic [7:0] v;
    reg_wr(`ADDR_COUNT, 8'h0E);
    @(posedge clk);
    reg_wr(`ADDR_STATUS, 8'h02);
    #1 check(cmf, 1'b1, "match flag set wins");
    reg_wr(`ADDR_STATUS, 8'h02);
    #1 check(cmf, 1'b0, "match flag cleared");
    reg_rd(`ADDR_STATUS, v);
    check(v[2:1], 2'b00, "status flag and output");
  endtask : t_flag

  // Reset in mid-run returns outputs and registers to zero
  task automatic t_rst_mid();
    logic [7:0] v;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({pin_o, pin_oe, ovf, cmf}, 4'h0, "outputs in reset");
    check(rdata, 8'h00, "read data in reset");
    @(posedge clk);
    rstn <= 1'b1;
    reg_rd(`ADDR_PORT, v);
    check(v, 8'h00, "port after reset");
    reg_rd(`ADDR_CTRL, v);
    check(v, `CTRL_RST, "ctrl after reset");
  endtask : t_rst_mid

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    clk   = 1'b0;
    rstn  = 1'b0;
    addr  = 5'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_dir();
    t_seq(8'h1B, 1'b0, 300);
    t_seq(8'h19, 1'b1, 520);
    t_period(8'h1B, 256);
    t_period(8'h19, 510);
    t_period(8'h2B, 2048);
    t_duty(8'h1B, 8'h10, 256, 17);
    t_duty(8'h1F, 8'h10, 256, 239);
    t_duty(8'h1B, 8'h00, 256, 1);
    t_duty(8'h1B, 8'hFF, 256, 256);
    t_duty(8'h1F, 8'hFF, 256, 0);
    t_duty(8'h17, 8'h80, 512, 256);
    t_duty(8'h13, 8'h10, 256, 256);
    t_duty(8'h19, 8'h10, 510, 32);
    t_duty(8'h1D, 8'h10, 510, 478);
    t_duty(8'h19, 8'h00, 510, 0);
    t_duty(8'h19, 8'hFF, 510, 510);
    t_duty(8'h18, 8'h10, 256, 0);
    t_flag();
    t_rst_mid();
    end_of_test();
  end

  // Watchdog well past the expected run length
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end

endmodule : timer8_pwm_waveform_modes_bench
